//--- emc_cfg.svh
// Register map, field positions, reset values and counts of the MAC control and status block.
// Assumes inclusion by the package and the design modules; holds definitions only.
`ifndef EMC_CFG_SVH
`define EMC_CFG_SVH

// --------------------------------------------------------------------------
// Register addresses
// --------------------------------------------------------------------------
`define EMC_ADR_CTRL 32'h400b0000
`define EMC_ADR_NCFG 32'h400b0004
`define EMC_ADR_NSTAT 32'h400b0008
`define EMC_ADR_TSTAT 32'h400b0014
`define EMC_ADR_RQPTR 32'h400b0018
`define EMC_ADR_HASHL 32'h400b0090
`define EMC_ADR_HASHH 32'h400b0094

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define EMC_CTL_START 9
`define EMC_CTL_HALT 10
`define EMC_NC_SPD 0
`define EMC_NC_FD 1
`define EMC_NC_JUMBO 3
`define EMC_NC_PROM 4
`define EMC_NC_NOBC 5
`define EMC_NC_MHASH 6
`define EMC_NC_UHASH 7
`define EMC_NC_BIG 8
`define EMC_NC_CLK_LO 10
`define EMC_NC_RTY 12
`define EMC_NC_PAE 13
`define EMC_NC_OFS_LO 14
`define EMC_NC_LCHK 16
`define EMC_NC_FCSD 17
`define EMC_NC_RXTX 18
`define EMC_NC_FCSI 19
`define EMC_NS_MDIO 1
`define EMC_NS_IDLE 2
`define EMC_TS_UBR 0
`define EMC_TS_COL 1
`define EMC_TS_RETRY_LIMIT_HIT 2
`define EMC_TS_TGO 3
`define EMC_TS_BEX 4
`define EMC_TS_COMP 5
`define EMC_TS_UND 6

// --------------------------------------------------------------------------
// Reset values, masks and counts
// --------------------------------------------------------------------------
`define EMC_NCFG_RST 32'h00000800
`define EMC_NCFG_MASK 32'h000ffdfb
`define EMC_TSTAT_W1C 7'h77
`define EMC_LEN_STD 14'd1518
`define EMC_LEN_BIG 14'd1536
`define EMC_LEN_JUMBO 14'd10240
`define EMC_TYPE_MIN 16'h0600
`define EMC_RQ_BUFS 10'd1023
`define EMC_RQ_STEP 32'h00000008
`define EMC_MGMT_BITS 7'd64
`define EMC_MDC_HALF_MIN 6'h04

`endif

//--- emc_mdc_div.sv
// Management clock divider: halves a count of 4, 8, 16 or 32 system clocks.
// Assumes run is a same-clock level; the clock rests low while run is low.
`timescale 1ns/1ps
`include "emc_cfg.svh"

module emc_mdc_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Control
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  // Clock out
  output logic mdc_o,
  output logic rise_o
);
  import emc_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic mdc;
    logic rise;
  } emc_div_t;

  emc_div_t s_r;
  emc_div_t s_nxt;
  logic [5:0] half;

  always_comb begin
    half = 6'(`EMC_MDC_HALF_MIN << sel_i);
    s_nxt = s_r;
    s_nxt.rise = 1'b0;
    if (!run_i) begin
      s_nxt.cnt = 6'h00;
      s_nxt.mdc = 1'b0;
    end else if (s_r.cnt == half - 6'h01) begin
      s_nxt.cnt = 6'h00;
      s_nxt.mdc = !s_r.mdc;
      s_nxt.rise = !s_r.mdc;
    end else begin
      s_nxt.cnt = s_r.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign mdc_o = s_r.mdc;
  assign rise_o = s_r.rise;

endmodule : emc_mdc_div

//--- emc_phy_model.sv
// PHY stand-in: collision, carrier and management data input line.
// Assumes the bench commands collisions and mdio drive; mdio has a pull-up.
`timescale 1ns/1ps

module emc_phy_model (
  // Commands from the bench
  input wire logic col_cmd_i,
  input wire logic mdio_low_i,
  // PHY pins
  output logic col_o,
  output logic crs_o,
  output logic mdio_o
);
  // Carrier rides along with a forced collision
  assign col_o = col_cmd_i;
  assign crs_o = col_cmd_i;
  // A released line floats up to the pull-up level
  assign mdio_o = !mdio_low_i;
endmodule : emc_phy_model

//--- emc_pkg.sv
// Shared types of the MAC control and status block.
// Assumes emc_cfg.svh is on the include path.
`include "emc_cfg.svh"

package emc_pkg;

  // ------------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [47:0] da;
    logic [13:0] len;
    logic [15:0] len_field;
    logic crc_ok;
    logic addr_match;
  } emc_rx_info_t;

  typedef struct packed {
    logic sof;
    logic eof;
    logic ubr_start;
    logic ubr_mid;
    logic late_grant;
    logic bus_err;
    logic buffers_exhausted;
    logic retry_lim;
  } emc_tx_evt_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } emc_apb_req_t;

  typedef enum logic [2:0] {
    EMC_TX_IDLE = 3'b001,
    EMC_TX_READY = 3'b010,
    EMC_TX_SEND = 3'b100
  } emc_tx_st_t;

endpackage : emc_pkg

//--- emc_tb.sv
// Directed bench for the MAC control and status block: APB tasks and tests.
// Assumes emc_pkg, emc_top and emc_phy_model are compiled before it.
`timescale 1ns/1ps
`include "emc_cfg.svh"

module testbench;
  import emc_pkg::*;
  // ----------
  // Signals
  // ----------
  localparam logic [31:0] a_ct = `EMC_ADR_CTRL;
  localparam logic [31:0] a_nc = `EMC_ADR_NCFG;
  localparam logic [31:0] a_ns = `EMC_ADR_NSTAT;
  localparam logic [31:0] a_ts = `EMC_ADR_TSTAT;
  localparam logic [31:0] a_rq = `EMC_ADR_RQPTR;
  logic clk_i = '0, rstn_i = '0, rx_done = '0, buf_used = '0, buf_wrap = '0, rxclk = '0, pause = '0, mgmt = '0;
  logic col_cmd = '0, mdio_low = '0, err_s, bf_s, a_s, d_s, pslverr, pready, speed, hdx, mdc, allow, txerr;
  logic badfcs, tcol, tcrs, bo1, acc, drp, fcsd, fcsi, rxtx, col, crs, mdio, slot = '0;
  logic [1:0] ofs;
  logic [31:0] prdata, rdat;
  logic [63:0] hv;
  emc_apb_req_t apb = '0;
  emc_tx_evt_t evt = '0;
  emc_rx_info_t info = '0;
  int fail_count = 0, compares = 0, p, n;

  always #10 clk_i = ~clk_i;

  emc_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .col_i(col), .crs_i(crs), .mdio_i(mdio), .speed_o(speed), .half_duplex_o(hdx),
    .mdc_o(mdc), .tx_evt_i(evt), .slot_tick_i(slot), .rxclk_tick_i(rxclk), .pause_rx_i(pause),
    .pause_quanta_i(16'h0003), .tx_allow_o(allow), .tx_err_o(txerr), .bad_fcs_o(badfcs), .tx_col_o(tcol),
    .tx_crs_o(tcrs), .backoff_one_slot_o(bo1), .rx_done_i(rx_done), .rx_info_i(info), .rx_buf_used_i(buf_used),
    .rx_buf_wrap_i(buf_wrap), .rx_accept_o(acc), .rx_drop_o(drp), .rx_offset_o(ofs), .fcs_discard_o(fcsd),
    .fcs_ignore_o(fcsi), .rx_during_tx_o(rxtx), .mgmt_start_i(mgmt));
  emc_phy_model phy (.col_cmd_i(col_cmd), .mdio_low_i(mdio_low), .col_o(col), .crs_o(crs), .mdio_o(mdio));

  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc

  // Request held until pready is seen high at a rising edge
  // Only the watchdog ends a wait for pready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rdat = prdata;
    err_s = pslverr;
    apb <= '0;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask : rdc

  task automatic wall;
    int k;
    k = 0;
    while (allow !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    chk(allow, 1'b1);
  endtask : wall

  // Pulses are caught over three cycles; the exact latency is the design's choice
  task automatic tev(input emc_tx_evt_t e);
    @(posedge clk_i);
    evt <= e;
    err_s = 1'b0;
    bf_s = 1'b0;
    repeat (3) begin
      @(posedge clk_i);
      evt <= '0;
      #1;
      err_s |= txerr;
      bf_s |= badfcs;
    end
  endtask : tev

  task automatic rxc(input logic [31:0] c, input logic [47:0] da, input logic [13:0] len, input logic [15:0] lf,
                     input logic [1:0] cm, input logic e);
    wr(a_nc, c);
    @(posedge clk_i);
    info <= '{da: da, len: len, len_field: lf, crc_ok: cm[1], addr_match: cm[0]};
    rx_done <= 1'b1;
    a_s = 1'b0;
    d_s = 1'b0;
    repeat (3) begin
      @(posedge clk_i);
      rx_done <= 1'b0;
      #1;
      a_s |= acc;
      d_s |= drp;
    end
    chk({a_s, d_s}, {e, !e});
  endtask : rxc

  task automatic bufs(input int k, input logic w);
    repeat (k) begin
      @(posedge clk_i);
      buf_used <= 1'b1;
      buf_wrap <= w;
      @(posedge clk_i);
      buf_used <= 1'b0;
    end
  endtask : bufs

  // Measures one management clock period in system clocks
  task automatic mper(output int q);
    int k;
    k = 0;
    while (mdc !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    q = 0;
    while (mdc === 1'b1 && q < 300) begin
      @(posedge clk_i);
      q++;
    end
    while (mdc !== 1'b1 && q < 300) begin
      @(posedge clk_i);
      q++;
    end
  endtask : mper

  function automatic logic [5:0] hidx(input logic [47:0] da);
    hidx = '0;
    for (int k = 0; k < 48; k++)
      hidx[k % 6] ^= da[k];
  endfunction : hidx

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ----------
  // Tests
  // ----------
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    finish_test;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(a_nc, '1, 32'h800);
    rdc(a_ts, '1, 32'h0);
    bus(1'b0, 32'h400b000c, 32'h0);
    chk(err_s, 1'b1);
    wr(a_nc, '1);
    rdc(a_nc, '1, 32'h000ffdfb);
    cyc(2);
    chk({speed, hdx, ofs, fcsd, fcsi, rxtx, bo1}, 8'hbf);
    for (int k = 0; k < 4; k++) begin
      wr(a_nc, (k << 14) | ((k & 1) << 18) | 32'h800);
      cyc(2);
      chk({speed, hdx, ofs, rxtx}, {2'b01, k[1:0], k[0]});
    end
    @(posedge clk_i);
    col_cmd <= 1'b1;
    cyc(5);
    chk({tcol, tcrs}, 2'b11);
    wr(a_nc, 32'h2);
    cyc(3);
    chk({tcol, tcrs}, 2'b00);
    @(posedge clk_i);
    col_cmd <= 1'b0;
    rxc(32'h0, 48'h2, 14'h64, 16'h0800, 2'b11, 1'b1);
    rxc(32'h0, 48'h2, 14'h64, 16'h0800, 2'b10, 1'b0);
    rxc(32'h10, 48'h2, 14'h64, 16'h0800, 2'b10, 1'b1);
    rxc(32'h0, '1, 14'h64, 16'h0800, 2'b10, 1'b1);
    rxc(32'h20, '1, 14'h64, 16'h0800, 2'b11, 1'b0);
    rxc(32'h0, 48'h2, 14'h5ee, 16'h0800, 2'b11, 1'b1);
    rxc(32'h0, 48'h2, 14'h5ef, 16'h0800, 2'b11, 1'b0);
    rxc(32'h100, 48'h2, 14'h600, 16'h0800, 2'b11, 1'b1);
    rxc(32'h100, 48'h2, 14'h601, 16'h0800, 2'b11, 1'b0);
    rxc(32'h8, 48'h2, 14'h2800, 16'h0800, 2'b11, 1'b1);
    rxc(32'h8, 48'h2, 14'h2801, 16'h0800, 2'b11, 1'b0);
    rxc(32'h0, 48'h2, 14'h64, 16'h0800, 2'b01, 1'b0);
    rxc(32'h80000, 48'h2, 14'h64, 16'h0800, 2'b01, 1'b1);
    rxc(32'h10000, 48'h2, 14'h64, 16'h00c8, 2'b11, 1'b0);
    rxc(32'h10000, 48'h2, 14'h64, 16'h0600, 2'b11, 1'b1);
    rxc(32'h0, 48'h2, 14'h64, 16'h00c8, 2'b11, 1'b1);
    hv = (64'h1 << hidx(48'h3)) | (64'h1 << hidx(48'h2));
    wr(`EMC_ADR_HASHL, hv[31:0]);
    wr(`EMC_ADR_HASHH, hv[63:32]);
    rxc(32'h40, 48'h3, 14'h64, 16'h0800, 2'b10, 1'b1);
    rxc(32'h80, 48'h3, 14'h64, 16'h0800, 2'b10, 1'b0);
    rxc(32'h80, 48'h2, 14'h64, 16'h0800, 2'b10, hv[hidx(48'h2)]);
    rxc(32'h80, 48'h4, 14'h64, 16'h0800, 2'b10, hv[hidx(48'h4)]);
    wr(a_rq, 32'h20001003);
    rdc(a_rq, '1, 32'h20001000);
    bufs(3, 1'b0);
    rdc(a_rq, '1, 32'h20001018);
    bufs(1, 1'b1);
    rdc(a_rq, '1, 32'h20001000);
    bufs(1023, 1'b0);
    rdc(a_rq, '1, 32'h20002ff8);
    bufs(1, 1'b0);
    rdc(a_rq, '1, 32'h20001000);
    wr(a_nc, 32'h0);
    wr(a_ct, 32'h200);
    wall;
    tev(8'h80);
    @(posedge clk_i);
    col_cmd <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      tev(8'h10 >> k);
      chk(bf_s, 1'b1);
    end
    @(posedge clk_i);
    col_cmd <= 1'b0;
    tev(8'h40);
    rdc(a_ts, 32'h7e, 32'h6a);
    wall;
    tev(8'h80);
    tev(8'h02);
    chk({err_s, bf_s}, 2'b11);
    rdc(a_ts, 32'h76, 32'h72);
    wr(a_ts, 32'h0);
    rdc(a_ts, 32'h76, 32'h72);
    wr(a_ts, 32'h77);
    rdc(a_ts, 32'h77, 32'h0);
    wr(a_ct, 32'h200);
    wall;
    tev(8'h80);
    wr(a_ct, 32'h400);
    rdc(a_ts, '1, 32'h08);
    tev(8'h40);
    cyc(4);
    chk(allow, 1'b0);
    rdc(a_ts, '1, 32'h20);
    wr(a_ct, 32'h200);
    tev(8'h20);
    tev(8'h01);
    rdc(a_ts, '1, 32'h25);
    wr(a_nc, 32'h3000);
    wr(a_ct, 32'h200);
    wall;
    @(posedge clk_i);
    pause <= 1'b1;
    @(posedge clk_i);
    pause <= 1'b0;
    cyc(2);
    chk(allow, 1'b0);
    repeat (5) begin
      @(posedge clk_i);
      rxclk <= 1'b1;
      @(posedge clk_i);
      rxclk <= 1'b0;
    end
    wall;
    wr(a_nc, 32'h1000);
    @(posedge clk_i);
    pause <= 1'b1;
    @(posedge clk_i);
    pause <= 1'b0;
    cyc(2);
    chk(allow, 1'b1);
    // Normal mode: pause counts slot ticks, receive clock ticks are ignored
    wr(a_nc, 32'h2000);
    @(posedge clk_i);
    pause <= 1'b1;
    @(posedge clk_i);
    pause <= 1'b0;
    repeat (5) begin
      @(posedge clk_i);
      rxclk <= 1'b1;
      @(posedge clk_i);
      rxclk <= 1'b0;
    end
    cyc(1);
    chk(allow, 1'b0);
    repeat (5) begin
      @(posedge clk_i);
      slot <= 1'b1;
      @(posedge clk_i);
      slot <= 1'b0;
    end
    wall;
    // Only dividers 32 and 64 keep the management clock at or below 2.5MHz here
    for (int s = 2; s < 4; s++) begin
      wr(a_nc, s << 10);
      @(posedge clk_i);
      mgmt <= 1'b1;
      @(posedge clk_i);
      mgmt <= 1'b0;
      rdc(a_ns, 32'h6, 32'h2);
      mper(p);
      chk(p, 8 << s);
      @(posedge clk_i);
      mdio_low <= 1'b1;
      // The pin passes two synchroniser stages before the status read sees it
      cyc(2);
      rdc(a_ns, 32'h6, 32'h0);
      @(posedge clk_i);
      mdio_low <= 1'b0;
      n = 0;
      do begin
        bus(1'b0, a_ns, 32'h0);
        n++;
      end while (rdat[2] !== 1'b1 && n < 2000);
      chk(rdat & 32'h6, 32'h6);
      repeat (70) begin
        cyc(1);
        chk(mdc, 1'b0);
      end
    end
    finish_test;
  end
endmodule : testbench

//--- emc_top.sv
// MAC configuration, status, transmit control, receive filter and receive queue pointer.
// Assumes the MAC core gives same-clock event strobes; collision, carrier and mdio come from pins.
`timescale 1ns/1ps
`include "emc_cfg.svh"

module emc_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // APB slave
  input wire emc_pkg::emc_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // PHY pins
  input wire logic col_i,
  input wire logic crs_i,
  input wire logic mdio_i,
  output logic speed_o,
  output logic half_duplex_o,
  output logic mdc_o,
  // Transmit core
  input wire emc_pkg::emc_tx_evt_t tx_evt_i,
  input wire logic slot_tick_i,
  input wire logic rxclk_tick_i,
  input wire logic pause_rx_i,
  input wire logic [15:0] pause_quanta_i,
  output logic tx_allow_o,
  output logic tx_err_o,
  output logic bad_fcs_o,
  output logic tx_col_o,
  output logic tx_crs_o,
  output logic backoff_one_slot_o,
  // Receive core
  input wire logic rx_done_i,
  input wire emc_pkg::emc_rx_info_t rx_info_i,
  input wire logic rx_buf_used_i,
  input wire logic rx_buf_wrap_i,
  output logic rx_accept_o,
  output logic rx_drop_o,
  output logic [1:0] rx_offset_o,
  output logic fcs_discard_o,
  output logic fcs_ignore_o,
  output logic rx_during_tx_o,
  // Management
  input wire logic mgmt_start_i
);
  import emc_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ncfg;
    logic [63:0] hash;
    logic [6:0] tsr;
    emc_tx_st_t st;
    logic halt_pend;
    logic [15:0] pause_cnt;
    logic [31:0] q_start;
    logic [31:0] q_ptr;
    logic [9:0] q_idx;
    logic mgmt_busy;
    logic [6:0] mgmt_bits;
    logic [1:0] col_s;
    logic [1:0] crs_s;
    logic [1:0] mdio_s;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic speed;
    logic half;
    logic tx_allow;
    logic tx_err;
    logic bad_fcs;
    logic tx_col;
    logic tx_crs;
    logic rx_accept;
    logic rx_drop;
    logic rxtx;
  } emc_state_t;

  emc_state_t s_r;
  emc_state_t s_nxt;
  logic mdc_rise;
  logic mdc_lvl;

  function automatic logic [5:0] emc_hash6(input logic [47:0] da);
    logic [5:0] h;
    h = 6'h00;
    for (int i = 0; i < 48; i++) begin
      h[i % 6] = h[i % 6] ^ da[i];
    end
    return h;
  endfunction : emc_hash6

  // --------------------------------------------------------------------------
  // Management clock
  // --------------------------------------------------------------------------
  emc_mdc_div u_mdc (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .run_i(s_r.mgmt_busy),
    .sel_i(s_r.ncfg[`EMC_NC_CLK_LO +: 2]),
    .mdc_o(mdc_lvl),
    .rise_o(mdc_rise)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic setup;
  logic wr;
  logic fd;
  logic [6:0] ts_set;
  logic [6:0] ts_clr;
  logic [13:0] max_len;
  logic bcast;
  logic hash_hit;
  logic len_err;
  logic rx_ok;
  logic [31:0] rd;
  logic rd_hit;

  always_comb begin
    s_nxt = s_r;
    setup = apb_i.psel && !apb_i.penable;
    wr = apb_i.psel && apb_i.penable && apb_i.pwrite && s_r.pready;
    fd = s_r.ncfg[`EMC_NC_FD];
    ts_set = 7'h00;
    ts_clr = 7'h00;

    // Pin synchronisers
    s_nxt.col_s = {s_r.col_s[0], col_i};
    s_nxt.crs_s = {s_r.crs_s[0], crs_i};
    s_nxt.mdio_s = {s_r.mdio_s[0], mdio_i};

    // Register reads are prepared in the setup cycle so data comes from a flop
    rd = 32'h00000000;
    rd_hit = 1'b1;
    case (apb_i.paddr)
      `EMC_ADR_CTRL: rd = {21'h000000, s_r.halt_pend, 10'h000};
      `EMC_ADR_NCFG: rd = s_r.ncfg;
      `EMC_ADR_NSTAT: begin
        rd[`EMC_NS_MDIO] = s_r.mdio_s[1];
        rd[`EMC_NS_IDLE] = !s_r.mgmt_busy;
      end
      `EMC_ADR_TSTAT: rd = {25'h0000000, s_r.tsr};
      `EMC_ADR_RQPTR: rd = s_r.q_ptr;
      `EMC_ADR_HASHL: rd = s_r.hash[31:0];
      `EMC_ADR_HASHH: rd = s_r.hash[63:32];
      default: rd_hit = 1'b0;
    endcase
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.prdata = apb_i.pwrite ? 32'h00000000 : rd;
      s_nxt.pslverr = !rd_hit;
    end

    // Register writes at the access edge
    if (wr && !s_r.pslverr) begin
      case (apb_i.paddr)
        `EMC_ADR_NCFG: s_nxt.ncfg = apb_i.pwdata & `EMC_NCFG_MASK;
        `EMC_ADR_TSTAT: ts_clr = apb_i.pwdata[6:0] & `EMC_TSTAT_W1C;
        `EMC_ADR_RQPTR: begin
          s_nxt.q_start = {apb_i.pwdata[31:2], 2'b00};
          s_nxt.q_ptr = {apb_i.pwdata[31:2], 2'b00};
          s_nxt.q_idx = 10'h000;
        end
        `EMC_ADR_HASHL: s_nxt.hash[31:0] = apb_i.pwdata;
        `EMC_ADR_HASHH: s_nxt.hash[63:32] = apb_i.pwdata;
        default: ;
      endcase
    end

    // Transmit control
    s_nxt.tx_err = 1'b0;
    s_nxt.bad_fcs = 1'b0;
    case (s_r.st)
      EMC_TX_IDLE: begin
        s_nxt.halt_pend = 1'b0;
        if (wr && apb_i.paddr == `EMC_ADR_CTRL && apb_i.pwdata[`EMC_CTL_START]
            && !apb_i.pwdata[`EMC_CTL_HALT]) begin
          s_nxt.st = EMC_TX_READY;
        end
      end
      EMC_TX_READY: begin
        if (wr && apb_i.paddr == `EMC_ADR_CTRL && apb_i.pwdata[`EMC_CTL_HALT]) begin
          s_nxt.st = EMC_TX_IDLE;
        end else if (tx_evt_i.ubr_start) begin
          s_nxt.st = EMC_TX_IDLE;
          ts_set[`EMC_TS_UBR] = 1'b1;
        end else if (tx_evt_i.sof && s_r.tx_allow) begin
          s_nxt.st = EMC_TX_SEND;
        end
      end
      EMC_TX_SEND: begin
        if (wr && apb_i.paddr == `EMC_ADR_CTRL && apb_i.pwdata[`EMC_CTL_HALT]) begin
          s_nxt.halt_pend = 1'b1;
        end
        if (tx_evt_i.buffers_exhausted) begin
          s_nxt.st = EMC_TX_IDLE;
          s_nxt.tx_err = 1'b1;
          s_nxt.bad_fcs = 1'b1;
          ts_set[`EMC_TS_BEX] = 1'b1;
        end else if (tx_evt_i.eof) begin
          s_nxt.st = s_nxt.halt_pend ? EMC_TX_IDLE : EMC_TX_READY;
          ts_set[`EMC_TS_COMP] = 1'b1;
        end
        if (tx_evt_i.late_grant || tx_evt_i.bus_err || tx_evt_i.ubr_mid) begin
          s_nxt.bad_fcs = 1'b1;
          ts_set[`EMC_TS_UND] = 1'b1;
        end
        if (tx_evt_i.ubr_mid) begin
          ts_set[`EMC_TS_UBR] = 1'b1;
        end
      end
      default: s_nxt.st = EMC_TX_IDLE;
    endcase
    if (tx_evt_i.retry_lim) begin
      ts_set[`EMC_TS_RETRY_LIMIT_HIT] = 1'b1;
    end
    // Collision and carrier are not looked at in full duplex
    s_nxt.tx_col = s_r.col_s[1] && !fd;
    s_nxt.tx_crs = s_r.crs_s[1] && !fd;
    if (s_r.col_s[1] && !fd && s_r.st == EMC_TX_SEND) begin
      ts_set[`EMC_TS_COL] = 1'b1;
    end

    // Sticky flags: hardware set beats a software clear in the same cycle
    s_nxt.tsr = (s_r.tsr & ~ts_clr) | ts_set;
    s_nxt.tsr[`EMC_TS_TGO] = s_nxt.st != EMC_TX_IDLE;

    // Pause timer
    if (pause_rx_i && s_r.ncfg[`EMC_NC_PAE]) begin
      s_nxt.pause_cnt = pause_quanta_i;
    end else if (s_r.pause_cnt != 16'h0000) begin
      if (s_r.ncfg[`EMC_NC_RTY] ? rxclk_tick_i : slot_tick_i) begin
        s_nxt.pause_cnt = s_r.pause_cnt - 16'h0001;
      end
    end
    // New frames wait for an empty pause timer; a running frame is left alone
    s_nxt.tx_allow = s_r.st == EMC_TX_READY && s_r.pause_cnt == 16'h0000 && !tx_evt_i.sof;

    // Receive filter
    max_len = s_r.ncfg[`EMC_NC_JUMBO] ? `EMC_LEN_JUMBO :
      (s_r.ncfg[`EMC_NC_BIG] ? `EMC_LEN_BIG : `EMC_LEN_STD);
    bcast = &rx_info_i.da;
    hash_hit = s_r.hash[emc_hash6(rx_info_i.da)] &&
      (rx_info_i.da[0] ? s_r.ncfg[`EMC_NC_MHASH] : s_r.ncfg[`EMC_NC_UHASH]);
    len_err = s_r.ncfg[`EMC_NC_LCHK] && rx_info_i.len_field < `EMC_TYPE_MIN &&
      {2'b00, rx_info_i.len} < rx_info_i.len_field;
    rx_ok = (rx_info_i.crc_ok || s_r.ncfg[`EMC_NC_FCSI]) &&
      rx_info_i.len <= max_len && !len_err;
    s_nxt.rx_accept = 1'b0;
    s_nxt.rx_drop = 1'b0;
    if (rx_done_i) begin
      if (rx_ok && (s_r.ncfg[`EMC_NC_PROM] ||
          (bcast ? !s_r.ncfg[`EMC_NC_NOBC] : (rx_info_i.addr_match || hash_hit)))) begin
        s_nxt.rx_accept = 1'b1;
      end else begin
        s_nxt.rx_drop = 1'b1;
      end
    end

    // Receive queue pointer
    if (rx_buf_used_i) begin
      if (rx_buf_wrap_i || s_r.q_idx == `EMC_RQ_BUFS) begin
        s_nxt.q_ptr = s_r.q_start;
        s_nxt.q_idx = 10'h000;
      end else begin
        s_nxt.q_ptr = s_r.q_ptr + `EMC_RQ_STEP;
        s_nxt.q_idx = s_r.q_idx + 10'h001;
      end
    end

    // Management operation runs for a fixed number of clock periods
    if (!s_r.mgmt_busy) begin
      s_nxt.mgmt_busy = mgmt_start_i;
      s_nxt.mgmt_bits = 7'h00;
    end else if (mdc_rise) begin
      s_nxt.mgmt_bits = s_r.mgmt_bits + 7'h01;
      if (s_r.mgmt_bits == `EMC_MGMT_BITS - 7'h01) begin
        s_nxt.mgmt_busy = 1'b0;
      end
    end

    // Pins
    s_nxt.speed = s_r.ncfg[`EMC_NC_SPD];
    s_nxt.half = !fd;
    s_nxt.rxtx = fd || s_r.ncfg[`EMC_NC_RXTX];
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.ncfg <= `EMC_NCFG_RST;
      s_r.st <= EMC_TX_IDLE;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign speed_o = s_r.speed;
  assign half_duplex_o = s_r.half;
  assign mdc_o = mdc_lvl;
  assign tx_allow_o = s_r.tx_allow;
  assign tx_err_o = s_r.tx_err;
  assign bad_fcs_o = s_r.bad_fcs;
  assign tx_col_o = s_r.tx_col;
  assign tx_crs_o = s_r.tx_crs;
  assign backoff_one_slot_o = s_r.ncfg[`EMC_NC_RTY];
  assign rx_accept_o = s_r.rx_accept;
  assign rx_drop_o = s_r.rx_drop;
  assign rx_offset_o = s_r.ncfg[`EMC_NC_OFS_LO +: 2];
  assign fcs_discard_o = s_r.ncfg[`EMC_NC_FCSD];
  assign fcs_ignore_o = s_r.ncfg[`EMC_NC_FCSI];
  assign rx_during_tx_o = s_r.rxtx;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i || !ce_i);

  sequence seq_halt_in_frame;
    s_r.st == EMC_TX_SEND && s_r.halt_pend && !tx_evt_i.eof && !tx_evt_i.buffers_exhausted;
  endsequence
  sequence seq_mgmt_quiet;
    !s_r.mgmt_busy [*2];
  endsequence
  sequence seq_bex_hit;
    s_r.st == EMC_TX_SEND && tx_evt_i.buffers_exhausted;
  endsequence

  a_halt_waits_eof: assert property (seq_halt_in_frame |=> s_r.st == EMC_TX_SEND)
    else $error("halt stopped a frame in flight");
  a_speed_pin: assert property (##1 speed_o == $past(s_r.ncfg[`EMC_NC_SPD]))
    else $error("speed pin does not follow config");
  a_duplex_pin_ign: assert property (fd |=> !tx_col_o && !half_duplex_o)
    else $error("full duplex saw collision");
  a_promisc_take: assert property (rx_done_i && s_r.ncfg[`EMC_NC_PROM] && rx_info_i.crc_ok
    && rx_info_i.len <= `EMC_LEN_STD && !s_r.ncfg[`EMC_NC_LCHK] |=> rx_accept_o)
    else $error("promiscuous frame dropped");
  a_bcast_reject: assert property (rx_done_i && (&rx_info_i.da) && s_r.ncfg[`EMC_NC_NOBC]
    && !s_r.ncfg[`EMC_NC_PROM] |=> rx_drop_o && !rx_accept_o)
    else $error("broadcast frame accepted");
  a_long_reject: assert property (rx_done_i && rx_info_i.len > `EMC_LEN_STD && !s_r.ncfg[`EMC_NC_BIG]
    && !s_r.ncfg[`EMC_NC_JUMBO] |=> rx_drop_o)
    else $error("long frame accepted");
  a_mdc_quiet: assert property (seq_mgmt_quiet |-> !mdc_o)
    else $error("management clock moved while idle");
  a_mgmt_idle_flag: assert property (!s_r.mgmt_busy && mgmt_start_i |=> s_r.mgmt_busy [*3])
    else $error("idle flag did not drop");
  a_pause_hold: assert property (s_r.pause_cnt != 16'h0000 |=> !tx_allow_o)
    else $error("frame allowed during pause");
  a_bex_stop: assert property (seq_bex_hit |=> tx_err_o && bad_fcs_o && s_r.st == EMC_TX_IDLE
    && s_r.tsr[`EMC_TS_BEX])
    else $error("buffers exhausted not handled");
  a_und_flag: assert property (s_r.st == EMC_TX_SEND && (tx_evt_i.late_grant || tx_evt_i.bus_err)
    |=> bad_fcs_o && s_r.tsr[`EMC_TS_UND])
    else $error("underrun not flagged");
  a_queue_wrap: assert property (rx_buf_used_i && rx_buf_wrap_i |=> s_r.q_ptr == s_r.q_start)
    else $error("queue pointer did not wrap");
  a_flag_set_wins: assert property (ts_set[`EMC_TS_COMP] && ts_clr[`EMC_TS_COMP]
    |=> s_r.tsr[`EMC_TS_COMP])
    else $error("set lost to clear");
  a_flag_no_wset: assert property (!s_r.tsr[`EMC_TS_UND] && ts_set[`EMC_TS_UND] == 1'b0
    |=> !s_r.tsr[`EMC_TS_UND])
    else $error("underrun flag set without cause");

endmodule : emc_top
